// ==== hw/ppc_pkg.sv ====
// Constants and types shared by the port pin control block.
package ppc_pkg;

	typedef logic [17:0] ppc_vec_t;
	typedef ppc_vec_t [4:0] ppc_pvec_t;

	// Pin edge that raises a flag.
	typedef enum logic [1:0] {
		IRQ_OFF = 2'h0,
		IRQ_RISE = 2'h1,
		IRQ_BOTH = 2'h3,
		IRQ_FALL = 2'h2
	} ppc_irqc_t;

	typedef struct packed {
		logic [2:0] mux;
		ppc_irqc_t irqc;
		logic dmas;
		logic ps;
		logic pe;
		logic pfe;
		logic ode;
		logic dse;
	} ppc_cfg_t;

	// Per port vectors, index 0 is port A and index 4 is port E.
	localparam ppc_pvec_t PIN_EXIST = {18'h1_ffff, 18'h3_ffff,
		18'h3_ffff, 18'h3_ffff, 18'h3_ffff};
	localparam ppc_pvec_t PS_RST = {18'h0_0000, 18'h0_0008,
		18'h0_0000, 18'h0_0000, 18'h0_0030};
	localparam ppc_pvec_t PE_RST = {18'h0_0000, 18'h0_0008,
		18'h0_0010, 18'h0_0000, 18'h0_0030};
	localparam ppc_pvec_t PFE_CAP = {18'h0_0000, 18'h0_0008,
		18'h0_0000, 18'h0_0000, 18'h0_0020};
	localparam ppc_pvec_t PFE_RST = {18'h0_0000, 18'h0_0000,
		18'h0_0000, 18'h0_0000, 18'h0_0020};
	localparam ppc_pvec_t DSE_CAP = {18'h0_0003, 18'h1_8003,
		18'h0_0000, 18'h0_0030, 18'h0_0000};
	localparam ppc_pvec_t ALT_FUNCTION_SEVEN_RST = {18'h0_0000, 18'h0_0008,
		18'h0_0010, 18'h0_0000, 18'h0_0030};

	localparam logic [2:0] MUX_ALT_FUNCTION_ZERO = 3'h0;
	localparam logic [2:0] MUX_ALT_FUNCTION_SEVEN = 3'h7;
	localparam logic [2:0] NMI_PORT = 3'h3;
	localparam logic [4:0] NMI_PIN = 5'h03;
	localparam logic [2:0] GF_PORT = 3'h4;
	localparam logic [2:0] GF_LAST = 3'h3;

	// Address map: port p at p * 0x80, pin control words first.
	localparam logic [2:0] NUM_PORTS = 3'h5;
	localparam logic [4:0] NUM_PINS = 5'h12;
	localparam logic [6:0] STAT_OFS = 7'h48;
	localparam logic [6:0] MASK_OFS = 7'h4c;
	localparam logic [6:0] LOCK_OFS = 7'h50;

	localparam int F_PS = 0;
	localparam int F_PE = 1;
	localparam int F_PFE = 4;
	localparam int F_ODE = 5;
	localparam int F_DSE = 6;
	localparam int F_MUX = 8;
	localparam int F_IRQC = 16;
	localparam int F_DMAS = 18;
	localparam int F_FLAG = 24;
	localparam int F_LOCK = 0;

endpackage

// ==== hw/ppc_port_ctrl.sv ====
// Pin control, multiplexing and pin interrupts for ports A to E.
`timescale 1ns/1ps
module ppc_port_ctrl
	import ppc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ppc_pvec_t pin_in,
	input wire logic [4:0][17:0][7:0] fn_out,
	input wire logic [4:0][17:0][7:0] fn_oe,
	input wire logic [4:0][17:0][7:0] od_cap,
	output ppc_pvec_t pin_out,
	output ppc_pvec_t pin_oe,
	output ppc_pvec_t pull_up,
	output ppc_pvec_t pull_dn,
	output ppc_pvec_t pfilt_en,
	output ppc_pvec_t hi_drive,
	output ppc_pvec_t in_sync,
	output logic nmi_req,
	output logic irq,
	output logic [4:0] dma_req
);

	typedef struct packed {
		ppc_cfg_t [4:0][17:0] cfg;
		ppc_pvec_t flag;
		ppc_pvec_t mask;
		ppc_pvec_t s1;
		ppc_pvec_t s2;
		ppc_pvec_t inp;
		logic [17:0][2:0] gcnt;
		logic [4:0] lock;
		ppc_pvec_t pout;
		ppc_pvec_t poe;
		ppc_pvec_t pu;
		ppc_pvec_t pd;
		ppc_pvec_t pfe;
		ppc_pvec_t dse;
		logic nmi;
		logic irq;
		logic [4:0] dma;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic run;
	} ppc_state_t;

	ppc_state_t q;
	ppc_state_t next_q;
	ppc_pvec_t set_v;
	ppc_pvec_t odv;
	ppc_pvec_t dsel;

	always_comb begin
		logic [2:0] pt;
		logic [4:0] pn;
		logic vport;
		logic hit_pin;
		logic hit_st;
		logic hit_mk;
		logic hit_lk;
		logic wr;
		logic [31:0] rd;
		logic [2:0] m;
		logic o;
		logic e;
		ppc_pvec_t clr;
		ppc_pvec_t dmv;
		ppc_cfg_t c;
		pt = '0;
		pn = '0;
		vport = 1'b0;
		hit_pin = 1'b0;
		hit_st = 1'b0;
		hit_mk = 1'b0;
		hit_lk = 1'b0;
		wr = 1'b0;
		rd = '0;
		m = '0;
		o = 1'b0;
		e = 1'b0;
		clr = '0;
		dmv = '0;
		c = '0;
		next_q = q;
		set_v = '0;
		odv = '0;
		next_q.run = 1'b1;

		vport = paddr[11:10] == 2'b00 && paddr[9:7] < NUM_PORTS
			&& paddr[1:0] == 2'b00;
		pt = vport ? paddr[9:7] : 3'h0;
		pn = paddr[6:2] < NUM_PINS ? paddr[6:2] : 5'h00;
		hit_pin = vport && paddr[6:0] < STAT_OFS
			&& paddr[6:2] < NUM_PINS && PIN_EXIST[pt][pn];
		hit_st = vport && paddr[6:0] == STAT_OFS;
		hit_mk = vport && paddr[6:0] == MASK_OFS;
		hit_lk = vport && paddr[6:0] == LOCK_OFS;

		// Zero wait state slave: answer is prepared in the setup cycle.
		if (psel && !penable) begin
			c = q.cfg[pt][pn];
			if (hit_pin) begin
				rd[F_PS] = c.ps;
				rd[F_PE] = c.pe;
				rd[F_PFE] = c.pfe;
				rd[F_ODE] = c.ode;
				rd[F_DSE] = c.dse;
				rd[F_MUX +: 3] = c.mux;
				rd[F_IRQC +: 2] = c.irqc;
				rd[F_DMAS] = c.dmas;
				rd[F_FLAG] = q.flag[pt][pn];
			end else if (hit_st) begin
				rd[17:0] = q.flag[pt];
			end else if (hit_mk) begin
				rd[17:0] = q.mask[pt];
			end else if (hit_lk) begin
				rd[F_LOCK] = q.lock[pt];
			end
			next_q.rdata = rd;
			next_q.err = !(hit_pin || hit_st || hit_mk || hit_lk);
			next_q.ready = 1'b1;
		end else begin
			next_q.ready = 1'b0;
			next_q.err = 1'b0;
			next_q.rdata = '0;
		end

		wr = psel && penable && q.ready && pwrite && !q.err;
		if (wr && hit_pin) begin
			c = q.cfg[pt][pn];
			// A locked port keeps its pad setup; events stay configurable.
			if (!q.lock[pt]) begin
				c.ps = pwdata[F_PS];
				c.pe = pwdata[F_PE];
				c.pfe = pwdata[F_PFE] & PFE_CAP[pt][pn];
				c.ode = pwdata[F_ODE];
				c.dse = pwdata[F_DSE] & DSE_CAP[pt][pn];
				c.mux = pwdata[F_MUX +: 3];
			end
			c.irqc = ppc_irqc_t'(pwdata[F_IRQC +: 2]);
			c.dmas = pwdata[F_DMAS];
			next_q.cfg[pt][pn] = c;
			clr[pt][pn] = pwdata[F_FLAG];
		end
		if (wr && hit_st) begin
			clr[pt] = pwdata[17:0];
		end
		if (wr && hit_mk) begin
			next_q.mask[pt] = pwdata[17:0] & PIN_EXIST[pt];
		end
		if (wr && hit_lk && pwdata[F_LOCK]) begin
			next_q.lock[pt] = 1'b1;
		end

		// Pad inputs pass three flops (s1, s2, inp); only port E adds the glitch filter.
		next_q.s1 = pin_in;
		next_q.s2 = q.s1;
		for (int p = 0; p < 5; p++) begin
			if (p[2:0] != GF_PORT) begin
				next_q.inp[p] = q.s2[p];
			end
		end
		for (int b = 0; b < 18; b++) begin
			if (q.s2[GF_PORT][b] == q.inp[GF_PORT][b]) begin
				next_q.gcnt[b] = 3'h0;
			end else if (q.gcnt[b] == GF_LAST) begin
				next_q.inp[GF_PORT][b] = q.s2[GF_PORT][b];
				next_q.gcnt[b] = 3'h0;
			end else begin
				next_q.gcnt[b] = q.gcnt[b] + 3'h1;
			end
		end

		for (int p = 0; p < 5; p++) begin
			for (int b = 0; b < 18; b++) begin
				c = next_q.cfg[p][b];
				dmv[p][b] = c.dmas;
				case (c.irqc)
					IRQ_RISE: set_v[p][b] = next_q.inp[p][b]
						&& !q.inp[p][b];
					IRQ_FALL: set_v[p][b] = !next_q.inp[p][b]
						&& q.inp[p][b];
					IRQ_BOTH: set_v[p][b] = next_q.inp[p][b]
						!= q.inp[p][b];
					default: set_v[p][b] = 1'b0;
				endcase
				set_v[p][b] = set_v[p][b] & PIN_EXIST[p][b];

				// Function zero leaves the pad undriven.
				m = c.mux;
				o = m != MUX_ALT_FUNCTION_ZERO && fn_out[p][b][m];
				e = m != MUX_ALT_FUNCTION_ZERO && fn_oe[p][b][m];
				odv[p][b] = c.ode && m != MUX_ALT_FUNCTION_ZERO
					&& od_cap[p][b][m];
				next_q.pout[p][b] = odv[p][b] ? 1'b0 : o;
				next_q.poe[p][b] = (odv[p][b] ? !o && e : e)
					&& PIN_EXIST[p][b];
				next_q.pu[p][b] = c.pe && c.ps;
				next_q.pd[p][b] = c.pe && !c.ps;
				next_q.pfe[p][b] = c.pfe;
				next_q.dse[p][b] = c.dse;
			end
		end

		// A new edge in the clearing cycle keeps its flag set.
		next_q.flag = (q.flag & ~clr) | set_v;
		next_q.irq = |(next_q.flag & next_q.mask & ~dmv);
		for (int p = 0; p < 5; p++) begin
			next_q.dma[p] = |(next_q.flag[p] & dmv[p]);
		end

		next_q.nmi = q.cfg[NMI_PORT][NMI_PIN].mux == MUX_ALT_FUNCTION_SEVEN
			&& !q.inp[NMI_PORT][NMI_PIN];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			for (int p = 0; p < 5; p++) begin
				for (int b = 0; b < 18; b++) begin
					q.cfg[p][b].ps <= PS_RST[p][b];
					q.cfg[p][b].pe <= PE_RST[p][b];
					q.cfg[p][b].pfe <= PFE_RST[p][b];
					q.cfg[p][b].mux <= ALT_FUNCTION_SEVEN_RST[p][b] ? MUX_ALT_FUNCTION_SEVEN
						: MUX_ALT_FUNCTION_ZERO;
				end
			end
			q.pu <= PS_RST & PE_RST;
			q.pd <= ~PS_RST & PE_RST;
			q.pfe <= PFE_RST;
			// Synchronisers start at the idle high level, so the pulled-up
			// non-maskable pin raises no false request after reset.
			q.s1 <= '1;
			q.s2 <= '1;
			q.inp <= '1;
		end else begin
			q <= next_q;
		end
	end

	assign prdata = q.rdata;
	assign pready = q.ready;
	assign pslverr = q.err;
	assign pin_out = q.pout;
	assign pin_oe = q.poe;
	assign pull_up = q.pu;
	assign pull_dn = q.pd;
	assign pfilt_en = q.pfe;
	assign hi_drive = q.dse;
	assign in_sync = q.inp;
	assign nmi_req = q.nmi;
	assign irq = q.irq;
	assign dma_req = q.dma;

	// Event routing per pin, read by the status checks below.
	always_comb begin
		dsel = '0;
		for (int p = 0; p < 5; p++) begin
			for (int b = 0; b < 18; b++) begin
				dsel[p][b] = q.cfg[p][b].dmas;
			end
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	reset_pull_a: assert property (!q.run |->
		pull_up == (PS_RST & PE_RST) && pull_dn == (~PS_RST & PE_RST))
		else $error("pull direction wrong after reset");
	reset_pe_a: assert property (!q.run |->
		(pull_up | pull_dn) == PE_RST)
		else $error("pull enable wrong after reset");
	pfe_cap_a: assert property ((pfilt_en & ~PFE_CAP) == '0)
		else $error("passive filter on pin without control");
	pfe_reset_a: assert property (!q.run |-> pfilt_en == PFE_RST)
		else $error("passive filter wrong after reset");
	od_low_a: assert property ((pin_out & $past(odv)) == '0)
		else $error("open drain pin driven high");
	od_reset_a: assert property (!q.run |->
		q.cfg[0][4].ode == 1'b0 && q.cfg[2][4].ode == 1'b0)
		else $error("open drain set after reset");
	dse_cap_a: assert property ((hi_drive & ~DSE_CAP) == '0)
		else $error("high drive on pin without control");
	dse_reset_a: assert property (!q.run |=> hi_drive == '0)
		else $error("high drive set after reset");
	irq_level_a: assert property (irq ==
		|(q.flag & q.mask & ~dsel))
		else $error("interrupt output disagrees with status");
	flag_keep_a: assert property ((set_v != '0) |=>
		(q.flag & $past(set_v)) == $past(set_v))
		else $error("pin event lost");
	lock_hold_a: assert property (q.lock[0] |=>
		$stable(q.cfg[0][4].mux) && $stable(q.cfg[0][4].pe))
		else $error("locked port configuration changed");
	nmi_pin_a: assert property (nmi_req == $past(
		q.cfg[3][3].mux == MUX_ALT_FUNCTION_SEVEN && !q.inp[3][3]))
		else $error("non-maskable request wrong");
	mux_reset_a: assert property (!q.run |->
		q.cfg[0][4].mux == MUX_ALT_FUNCTION_SEVEN && q.cfg[3][3].mux == MUX_ALT_FUNCTION_SEVEN
		&& q.cfg[1][0].mux == MUX_ALT_FUNCTION_ZERO)
		else $error("mux reset value wrong");
	glitch_e_a: assert property ($changed(in_sync[4][2]) |->
		$past(q.s2[4][2], 1) == in_sync[4][2]
		&& $past(q.s2[4][2], 4) == in_sync[4][2])
		else $error("port E input passed a glitch");
	nofilt_a: assert property (in_sync[1][2] == $past(q.s2[1][2]))
		else $error("port B input delayed");
	dma_route_a: assert property (dma_req == {
		|(q.flag[4] & dsel[4]), |(q.flag[3] & dsel[3]),
		|(q.flag[2] & dsel[2]), |(q.flag[1] & dsel[1]),
		|(q.flag[0] & dsel[0])})
		else $error("DMA request disagrees with status");
	lock_keep_a: assert property (q.lock[0] |=> q.lock[0])
		else $error("lock bit cleared without reset");
	oe_reset_a: assert property (!q.run |-> pin_oe == '0)
		else $error("pad driven right after reset");
	nmi_off_a: assert property (q.cfg[3][3].mux != MUX_ALT_FUNCTION_SEVEN |=> !nmi_req)
		else $error("non-maskable request without its function");

endmodule

// ==== bench/ppc_pin_model.sv ====
// Pad and peripheral model on the far side of the port pin control block.
`timescale 1ns/1ps
module ppc_pin_model
	import ppc_pkg::*;
(
	input wire ppc_pvec_t ext,
	input wire ppc_pvec_t pin_out,
	input wire ppc_pvec_t pin_oe,
	output ppc_pvec_t pin_in,
	output logic [4:0][17:0][7:0] fn_out,
	output logic [4:0][17:0][7:0] fn_oe,
	output logic [4:0][17:0][7:0] od_cap
);
	// A driven pad reads back its own level, an undriven one the line.
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
	assign fn_out = {90{8'hff}};
	// Function seven is input only, so it never drives the pad.
	assign fn_oe = {90{8'h7e}};
	// Only function three stands for a bus or transmitter output.
	assign od_cap = {90{8'h08}};
endmodule

// ==== bench/ppc_port_ctrl_bench.sv ====
// Self-checking bench for the port pin control block.
`timescale 1ns/1ps
module ppc_port_ctrl_bench
	import ppc_pkg::*;
();
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] rst;
		logic [31:0] exp;
		logic err;
	} ppc_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic nmi_req, irq;
	logic [4:0] dma_req;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	ppc_pvec_t pin_in, pin_out, pin_oe, pull_up, pull_dn, pfilt_en;
	ppc_pvec_t hi_drive, in_sync, ext, e, seen;
	logic [4:0][17:0][7:0] fn_out, fn_oe, od_cap;
	int err_total = 0;
	int cmp_count = 0;
	ppc_row_t rows [10] = '{
		'{12'h010, 32'h0000_0703, 32'h0000_0020, 1'b0},
		'{12'h014, 32'h0000_0713, 32'h0000_0030, 1'b0},
		'{12'h110, 32'h0000_0702, 32'h0000_0020, 1'b0},
		'{12'h18c, 32'h0000_0703, 32'h0000_0030, 1'b0},
		'{12'h090, 32'h0000_0000, 32'h0000_0060, 1'b0},
		'{12'h1bc, 32'h0000_0000, 32'h0000_0060, 1'b0},
		'{12'h1c0, 32'h0000_0000, 32'h0000_0060, 1'b0},
		'{12'h204, 32'h0000_0000, 32'h0000_0060, 1'b0},
		'{12'h100, 32'h0000_0000, 32'h0000_0020, 1'b0},
		'{12'h3fc, 32'h0000_0000, 32'h0000_0000, 1'b1}};

	ppc_port_ctrl ppc_port_ctrl_i (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .fn_out(fn_out),
		.fn_oe(fn_oe), .od_cap(od_cap), .pin_out(pin_out),
		.pin_oe(pin_oe), .pull_up(pull_up), .pull_dn(pull_dn),
		.pfilt_en(pfilt_en), .hi_drive(hi_drive), .in_sync(in_sync),
		.nmi_req(nmi_req), .irq(irq), .dma_req(dma_req));
	ppc_pin_model ppc_pin_model_i (.ext(ext), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_in(pin_in), .fn_out(fn_out),
		.fn_oe(fn_oe), .od_cap(od_cap));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic finish_test;
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [89:0] s, input logic [89:0] x);
		cmp_count++;
		if (s !== x) begin
			err_total++;
			$display("BAD %0t seen %h want %h", $time, s, x);
		end
	endtask

	// The master waits for pready without assuming any latency.
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			err_total++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge pclk);
	endtask

	initial begin
		wait_n(3000);
		err_total++;
		finish_test;
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		ext = '1;
		wait_n(20);
		e = '0;
		e[0][5:4] = 2'h3;
		e[3][3] = 1'b1;
		chk(pull_up, e);
		e = '0;
		e[2][4] = 1'b1;
		chk(pull_dn, e);
		e = '0;
		e[0][5] = 1'b1;
		chk(pfilt_en, e);
		chk(hi_drive, '0);
		presetn <= 1'b1;
		wait_n(2);
		chk(pin_oe, '0);
		foreach (rows[i]) begin
			apb(1'b0, rows[i].a, '0);
			chk(rd, rows[i].rst);
			chk(er, rows[i].err);
			apb(1'b1, rows[i].a, 32'h0000_0070);
			apb(1'b0, rows[i].a, '0);
			chk(rd, rows[i].exp);
		end
		chk(hi_drive[1][4], 1'b1);
		apb(1'b1, 12'h080, 32'h0000_0320);
		wait_n(3);
		chk({pin_oe[1][0], pin_out[1][0]}, 2'b00);
		apb(1'b1, 12'h080, 32'h0000_0220);
		wait_n(3);
		chk({pin_oe[1][0], pin_out[1][0]}, 2'b11);
		apb(1'b1, 12'h18c, 32'h0000_0700);
		ext[3][3] <= 1'b0;
		wait_n(6);
		chk(nmi_req, 1'b1);
		apb(1'b1, 12'h18c, 32'h0000_0000);
		wait_n(3);
		chk(nmi_req, 1'b0);
		ext[1][1] <= 1'b0;
		ext[2][1] <= 1'b0;
		apb(1'b1, 12'h084, 32'h0001_0000);
		apb(1'b1, 12'h104, 32'h0005_0000);
		wait_n(6);
		ext[1][1] <= 1'b1;
		ext[2][1] <= 1'b1;
		wait_n(6);
		chk({irq, dma_req}, 6'h04);
		apb(1'b0, 12'h0c8, '0);
		chk(rd, 32'h0000_0002);
		apb(1'b1, 12'h0cc, 32'h0000_0002);
		wait_n(2);
		chk(irq, 1'b1);
		apb(1'b1, 12'h0c8, 32'h0000_0002);
		wait_n(2);
		chk(irq, 1'b0);
		ext[4][2] <= 1'b0;
		ext[1][2] <= 1'b0;
		wait_n(2);
		ext[4][2] <= 1'b1;
		ext[1][2] <= 1'b1;
		seen = '1;
		repeat (8) begin
			@(posedge pclk);
			seen = seen & in_sync;
		end
		chk({seen[4][2], seen[1][2]}, 2'b10);
		ext[4][2] <= 1'b0;
		wait_n(10);
		chk(in_sync[4][2], 1'b0);
		apb(1'b1, 12'h050, 32'h0000_0001);
		apb(1'b0, 12'h050, '0);
		chk(rd, 32'h0000_0001);
		apb(1'b1, 12'h010, 32'h0000_0300);
		apb(1'b0, 12'h010, '0);
		chk(rd, 32'h0000_0020);
		finish_test;
	end
endmodule
